// File: inc/enc_index_params.svh
`ifndef ENC_INDEX_PARAMS_SVH
`define ENC_INDEX_PARAMS_SVH

// register offsets
`define OFS_ENC_CONST 8'h10
`define OFS_ENC_COUNT 8'h11
`define OFS_INDEX_CFG 8'h12
`define OFS_INDEX_STATUS 8'h13
`define OFS_INDEX_LATCH 8'h14
`define OFS_ANGLE_SCALE 8'h17
`define OFS_ANGLE 8'h18
`define OFS_ANGLE_SELECT 8'h19
`define OFS_INT_STATUS 8'h1A
`define OFS_INT_MASK 8'h1B

// field widths and positions
`define CFG_WIDTH 14
`define SCALE_WIDTH 12
`define SCALE_FRAC_BITS 6
`define SELECT_RES_LSB 0
`define SELECT_LOAD_LSB 8
`define INT_INDEX_BIT 0
`define INT_LIMIT_BIT 1
`define INT_WIDTH 2

// reset values
`define RST_ENC_CONST 32'h0001_0000
`define RST_CFG 14'h0000
`define RST_SCALE 12'h000
`define RST_SELECT 4'h0

// fraction moduli for the count accumulator
`define MOD_BINARY 17'h1_0000
`define MOD_DECIMAL 17'h0_2710

// load angle limits in 256ths of an electrical period
`define LIMIT_0 8'h40
`define LIMIT_1 8'h48
`define LIMIT_2 8'h50
`define LIMIT_3 8'h58

`endif

// File: inc/enc_index_pkg.sv
package enc_index_pkg;

   typedef struct packed {
      logic decimal_scale;
      logic compare_on_encoder;
      logic [2:0] reserved;
      logic clear_on_event;
      logic fall_trigger;
      logic rise_trigger;
      logic clear_once;
      logic clear_continuous;
      logic skip_quadrature_qualify;
      logic pol_index;
      logic pol_b;
      logic pol_a;
   } index_cfg_type;

   typedef struct packed {
      logic [1:0] load_sel;
      logic [1:0] resolution;
   } angle_select_type;

   typedef struct packed {
      logic limit_active;
      logic over_positive;
      logic over_negative;
   } load_status_type;

   typedef struct packed {
      logic index_n;
      logic b;
      logic a;
   } encoder_pins_type;

endpackage

// File: hw/pin_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser; only the second stage is visible outside
module pin_sync #(
   parameter int WIDTH = 3
) (
   // clock
   input wire logic core_clk,
   // data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   // no reset: the stages fill from the pins while the core is held in
   // reset, so release never shows a stale level as a fresh edge
   always_ff @(posedge core_clk) begin
      stage1 <= async_in;
      sync_out <= stage1;
   end
endmodule

// File: hw/encoder_index_and_load_angle_control.sv
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "enc_index_params.svh"
// How it works
// - index qualifies only while A matches its polarity bit, unless skipped
// - index qualifies only while B matches its polarity bit, unless skipped
// - index active level comes from config bit 2
// - config bit 3 ignores A and B when qualifying the index
// - bit 4 clears the count for as long as the qualified index holds
// - bit 5 arms one event; only the next qualified index acts
// - bit 6 triggers on the index becoming active
// - bit 7 triggers on the index becoming inactive
// - every event latches the count; bit 8 also zeroes it
// - bit 12 picks motor position or encoder count for compare
// - bit 13 picks fraction units of 1/65536 or 1/10000
// - signed 6.6 scale is added per encoder count to the angle
// - zero scale disables vector control and limiting; reset is zero
// - 8-bit angle, 256 per period, readable and writable by software
// - resolution field picks which microstep bits form the motor angle
// - bits 9:8 limit load angle to 64, 72, 80 or 88 256ths
// - index event sets a status flag cleared by reading it
module encoder_index_and_load_angle_control (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // encoder pins
   input wire enc_index_pkg::encoder_pins_type enc_pins,
   // motion core
   input wire logic [31:0] motor_position,
   input wire logic [31:0] compare_value,
   input wire logic [12:0] microstep_position,
   // results
   output logic position_match_output,
   output logic [31:0] encoder_count,
   output enc_index_pkg::load_status_type load_status,
   output logic [7:0] load_angle,
   output logic irq
);
   import enc_index_pkg::*;

   index_cfg_type cfg;
   angle_select_type sel;
   encoder_pins_type pins;
   logic [31:0] enc_const;
   logic [15:0] enc_frac;
   logic [31:0] index_latch;
   logic index_status;
   logic armed;
   logic qual_prev;
   logic a_prev;
   logic b_prev;
   logic [`SCALE_WIDTH-1:0] scale;
   logic [13:0] angle_acc;
   logic [`INT_WIDTH-1:0] int_status;
   logic [`INT_WIDTH-1:0] int_mask;

   // pins cross into the clock domain before anything reads them
   pin_sync #(.WIDTH(3)) i_pin_sync (
      .core_clk(core_clk),
      .async_in(enc_pins),
      .sync_out(pins)
   );

   // write decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      return a == o;
   endfunction

   wire wr_const = reg_wr && hit(reg_addr, `OFS_ENC_CONST);
   wire wr_count = reg_wr && hit(reg_addr, `OFS_ENC_COUNT);
   wire wr_cfg = reg_wr && hit(reg_addr, `OFS_INDEX_CFG);
   wire wr_scale = reg_wr && hit(reg_addr, `OFS_ANGLE_SCALE);
   wire wr_angle = reg_wr && hit(reg_addr, `OFS_ANGLE);
   wire wr_select = reg_wr && hit(reg_addr, `OFS_ANGLE_SELECT);
   wire wr_int_status = reg_wr && hit(reg_addr, `OFS_INT_STATUS);
   wire wr_int_mask = reg_wr && hit(reg_addr, `OFS_INT_MASK);
   wire rd_status = reg_rd && hit(reg_addr, `OFS_INDEX_STATUS);

   // index qualification
   wire index_active = (pins.index_n == cfg.pol_index);
   wire a_ok = (pins.a == cfg.pol_a);
   wire b_ok = (pins.b == cfg.pol_b);
   wire ab_ok = cfg.skip_quadrature_qualify || (a_ok && b_ok);
   wire qual = index_active && ab_ok;
   wire rise = qual && !qual_prev;
   wire fall = !qual && qual_prev;
   wire edge_mode = cfg.rise_trigger || cfg.fall_trigger;
   wire edge_hit = (cfg.rise_trigger && rise) || (cfg.fall_trigger && fall);
   wire trigger = edge_mode ? edge_hit : qual;
   // in single-shot mode only an armed trigger acts
   wire index_event = trigger && (!cfg.clear_once || armed);
   wire clear_now = (cfg.clear_continuous && qual)
      || (index_event && cfg.clear_on_event);

   // quadrature decode; a double transition is dropped as noise
   wire a_chg = pins.a ^ a_prev;
   wire b_chg = pins.b ^ b_prev;
   wire step = a_chg ^ b_chg;
   wire step_up = pins.a ^ b_prev;

   // count accumulator: integer part plus a fraction that wraps at mod
   wire [16:0] frac_mod = cfg.decimal_scale ? `MOD_DECIMAL
      : `MOD_BINARY;
   wire [16:0] cf = {1'b0, enc_const[15:0]};
   wire [16:0] fr = {1'b0, enc_frac};
   wire [16:0] frac_sum = fr + cf;
   wire frac_carry = frac_sum >= frac_mod;
   wire frac_borrow = fr < cf;
   wire [16:0] frac_up = frac_carry ? frac_sum - frac_mod : frac_sum;
   wire [16:0] frac_dn = frac_borrow ? fr + frac_mod - cf : fr - cf;
   wire [31:0] int_part = {{16{enc_const[31]}}, enc_const[31:16]};
   wire [31:0] count_up = encoder_count + int_part
      + {31'h0000_0000, frac_carry};
   wire [31:0] count_dn = encoder_count - int_part
      - {31'h0000_0000, frac_borrow};
   wire [31:0] next_count = step_up ? count_up : count_dn;
   wire [15:0] next_frac = step_up ? frac_up[15:0] : frac_dn[15:0];

   // vector angle: signed 6.6 scale per count, 8 integer angle bits
   wire [13:0] scale_ext = {{2{scale[`SCALE_WIDTH-1]}}, scale};
   wire [13:0] next_angle_acc = step_up ? angle_acc + scale_ext
      : angle_acc - scale_ext;
   wire [7:0] enc_angle = angle_acc[13:`SCALE_FRAC_BITS];
   wire vc_on = scale != `RST_SCALE;

   function automatic logic [7:0] motor_angle(input logic [1:0] res,
      input logic [12:0] adr);
      case (res)
         2'h0: return adr[12:5];
         2'h1: return adr[11:4];
         2'h2: return adr[9:2];
         default: return adr[7:0];
      endcase
   endfunction

   function automatic logic [7:0] load_limit(input logic [1:0] code);
      case (code)
         2'h0: return `LIMIT_0;
         2'h1: return `LIMIT_1;
         2'h2: return `LIMIT_2;
         default: return `LIMIT_3;
      endcase
   endfunction

   wire [7:0] mot_angle = motor_angle(sel.resolution,
      microstep_position);
   // difference wraps modulo one electrical period
   wire [7:0] diff = enc_angle - mot_angle;
   wire [7:0] limit = load_limit(sel.load_sel);
   wire [7:0] neg_limit = 8'h00 - limit;
   wire over_pos = vc_on && ($signed(diff) > $signed(limit));
   wire over_neg = vc_on && ($signed(diff) < $signed(neg_limit));
   wire limit_rise = (over_pos || over_neg) && !load_status.limit_active;

   // interrupt bits: set wins over a write-one clear
   wire [`INT_WIDTH-1:0] int_set = {limit_rise, index_event};
   wire [`INT_WIDTH-1:0] int_clr = wr_int_status
      ? reg_wdata[`INT_WIDTH-1:0] : {`INT_WIDTH{1'b0}};
   wire [`INT_WIDTH-1:0] next_int_status = int_set
      | (int_status & ~int_clr);
   wire next_index_status = index_event
      || (index_status && !rd_status);

   wire [31:0] cmp_src = cfg.compare_on_encoder ? encoder_count
      : motor_position;

   // write-only registers read back as zero
   wire [31:0] next_rdata =
      hit(reg_addr, `OFS_ENC_COUNT) ? encoder_count :
      hit(reg_addr, `OFS_INDEX_STATUS) ? {31'h0000_0000, index_status} :
      hit(reg_addr, `OFS_INDEX_LATCH) ? index_latch :
      hit(reg_addr, `OFS_ANGLE) ? {24'h00_0000, enc_angle} :
      hit(reg_addr, `OFS_INT_STATUS) ? {30'h0000_0000, int_status} :
      hit(reg_addr, `OFS_INT_MASK) ? {30'h0000_0000, int_mask} :
      32'h0000_0000;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cfg <= `RST_CFG;
         sel <= `RST_SELECT;
         scale <= `RST_SCALE;
         enc_const <= `RST_ENC_CONST;
         int_mask <= '0;
      end else begin
         if (wr_cfg) cfg <= reg_wdata[`CFG_WIDTH-1:0];
         if (wr_select) sel <= {reg_wdata[`SELECT_LOAD_LSB+1 -: 2],
            reg_wdata[`SELECT_RES_LSB+1 -: 2]};
         if (wr_scale) scale <= reg_wdata[`SCALE_WIDTH-1:0];
         if (wr_const) enc_const <= reg_wdata;
         if (wr_int_mask) int_mask <= reg_wdata[`INT_WIDTH-1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         qual_prev <= 1'b0;
         // live levels, so the first cycle after release sees no step
         a_prev <= pins.a;
         b_prev <= pins.b;
         armed <= 1'b0;
         index_status <= 1'b0;
         index_latch <= '0;
      end else begin
         qual_prev <= qual;
         a_prev <= pins.a;
         b_prev <= pins.b;
         index_status <= next_index_status;
         // rewriting the config with bit 5 set rearms the single shot
         if (wr_cfg) armed <= reg_wdata[5];
         else if (index_event && cfg.clear_once) armed <= 1'b0;
         if (index_event) index_latch <= encoder_count;
      end
   end

   // a clear beats both a software write and a step in the same cycle
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         encoder_count <= '0;
         enc_frac <= '0;
      end else if (clear_now) begin
         encoder_count <= '0;
         enc_frac <= '0;
      end else if (wr_count) begin
         encoder_count <= reg_wdata;
         enc_frac <= '0;
      end else if (step) begin
         encoder_count <= next_count;
         enc_frac <= next_frac;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) angle_acc <= '0;
      else if (wr_angle) angle_acc <= {reg_wdata[7:0], 6'h00};
      else if (step && vc_on) angle_acc <= next_angle_acc;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         load_status <= '0;
         load_angle <= '0;
         position_match_output <= 1'b0;
         int_status <= '0;
         reg_rdata <= '0;
      end else begin
         load_status <= {over_pos || over_neg, over_pos, over_neg};
         load_angle <= vc_on ? diff : 8'h00;
         position_match_output <= cmp_src == compare_value;
         int_status <= next_int_status;
         reg_rdata <= next_rdata;
      end
   end

   assign irq = |(int_status & int_mask);

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_event_unarmed;
      index_event && cfg.clear_once && !wr_cfg;
   endsequence

   // a config write in the gap may rearm, so the event after it is legal
   sequence s_disarmed;
      !armed ##1 (!index_event || $past(wr_cfg));
   endsequence

   a_status_set: assert property (
      index_event |=> index_status ##1 (index_status || $past(rd_status)))
      else $error("index status not set by event");

   a_status_rdclr: assert property (
      index_status && rd_status && !index_event |=> !index_status)
      else $error("index status not cleared by read");

   a_latch_copy: assert property (
      index_event |=> index_latch == $past(encoder_count))
      else $error("latch did not copy count");

   a_event_clear: assert property (
      index_event && cfg.clear_on_event |=> encoder_count == 32'h0)
      else $error("count not cleared on event");

   a_cont_clear: assert property (
      cfg.clear_continuous && qual |=> encoder_count == 32'h0)
      else $error("count not held clear while index active");

   a_once_disarm: assert property (
      s_event_unarmed |=> s_disarmed)
      else $error("single shot fired twice");

   a_rise_only: assert property (
      cfg.rise_trigger && !cfg.fall_trigger && trigger
      |-> qual && !qual_prev)
      else $error("rise trigger without rising index");

   a_fall_only: assert property (
      cfg.fall_trigger && !cfg.rise_trigger && trigger
      |-> !qual && qual_prev)
      else $error("fall trigger without falling index");

   a_level_mode: assert property (
      !edge_mode && !cfg.clear_once |-> index_event == qual)
      else $error("level mode event differs from index");

   a_vc_off: assert property (
      scale == 12'h000 && $past(scale) == 12'h000
      |-> !load_status.limit_active && load_angle == 8'h00)
      else $error("limit active with vector control off");

   a_match_src: assert property (
      ##1 position_match_output == ($past(cmp_src) == $past(compare_value)))
      else $error("compare output from wrong source");

   a_qual_ab: assert property (
      qual && !cfg.skip_quadrature_qualify |-> a_ok && b_ok)
      else $error("index qualified against A or B level");

   a_irq_level: assert property (
      index_event && int_mask[`INT_INDEX_BIT] && !wr_int_mask |=> irq)
      else $error("index event did not raise the interrupt");

   a_latch_hold: assert property (
      !index_event |=> $stable(index_latch))
      else $error("latch moved without an index event");

   a_angle_hold: assert property (
      scale == 12'h000 && !wr_angle |=> $stable(angle_acc))
      else $error("angle moved with vector control off");

   // the smallest limit is the floor for any flagged excursion
   a_over_pos: assert property (
      load_status.over_positive |-> $signed(load_angle) > $signed(`LIMIT_0))
      else $error("positive limit flag below the limit");

   a_over_neg: assert property (
      load_status.over_negative
      |-> $signed(load_angle) < $signed(8'h00 - `LIMIT_0))
      else $error("negative limit flag above the limit");
endmodule

// File: test/quad_encoder_model.sv
`timescale 1ns/1ps
// quadrature encoder with index; one gray state per step
module quad_encoder_model (
   // clock
   input wire logic core_clk,
   // control from the bench
   input wire logic step_up,
   input wire logic step_dn,
   input wire logic index_pin,
   // encoder pins
   output enc_index_pkg::encoder_pins_type pins
);
   import enc_index_pkg::*;
   logic [1:0] phase = 2'h0;
   always_ff @(posedge core_clk) begin
      if (step_up) begin
         phase <= phase + 2'h1;
      end else if (step_dn) begin
         phase <= phase - 2'h1;
      end
   end
   // only a or b moves per step, so no step is ever refused as ambiguous
   assign pins = '{index_n: index_pin, b: phase[1], a: phase[1] ^ phase[0]};
endmodule

// File: test/test_encoder_index_and_load_angle_control.sv
`timescale 1ns/1ps
`include "enc_index_params.svh"
module test_encoder_index_and_load_angle_control;
   import enc_index_pkg::*;
   logic core_clk, rst_n, reg_wr, reg_rd, step_up, step_dn, index_pin;
   logic [7:0] reg_addr, load_angle;
   logic [31:0] reg_wdata, reg_rdata, motor_position, compare_value;
   logic [31:0] encoder_count;
   logic [12:0] microstep_position;
   logic position_match_output, irq;
   encoder_pins_type pins;
   load_status_type load_status;
   int n_fail = 0;
   int checks_done = 0;
   logic [1:0] ph = 2'h0;

   encoder_index_and_load_angle_control i_encoder_index_and_load_angle_control (
      .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .enc_pins(pins),
      .motor_position(motor_position), .compare_value(compare_value),
      .microstep_position(microstep_position),
      .position_match_output(position_match_output),
      .encoder_count(encoder_count), .load_status(load_status),
      .load_angle(load_angle), .irq(irq));
   quad_encoder_model i_quad_encoder_model (.core_clk(core_clk),
      .step_up(step_up), .step_dn(step_dn), .index_pin(index_pin),
      .pins(pins));

   task automatic complete_run();
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask
   // pins need three steady cycles per state; six leaves margin for sync
   task automatic step(input logic up);
      @(posedge core_clk);
      step_up <= up;
      step_dn <= !up;
      @(posedge core_clk);
      step_up <= 1'b0;
      step_dn <= 1'b0;
      ph = up ? ph + 2'h1 : ph - 2'h1;
      idle(6);
   endtask
   task automatic idx(input logic lvl);
      @(posedge core_clk);
      index_pin <= lvl;
      idle(6);
   endtask

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      #500000;
      n_fail++;
      complete_run();
   end

   initial begin
      logic [31:0] c, cfg, nc;
      logic [7:0] mang;
      logic signed [7:0] dv;
      logic q, qo;
      int lim;
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      step_up = 1'b0;
      step_dn = 1'b0;
      // inactive for the reset polarity, so no event follows release
      index_pin = 1'b1;
      motor_position = 32'h0;
      compare_value = 32'h1;
      microstep_position = 13'h0;
      void'($urandom(32'h02F7));
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      microstep_position <= 13'($urandom);
      idle(4);
      chk({24'h0, load_angle}, 32'h0);
      rchk(`OFS_INDEX_STATUS, 32'h0);
      rchk(8'h05, 32'h0);
      // a half count in decimal units: two steps make one whole count
      wr(`OFS_ENC_CONST, 32'h0000_1388);
      wr(`OFS_INDEX_CFG, 32'h0000_2000);
      step(1'b1);
      step(1'b1);
      chk(encoder_count, 32'h1);
      wr(`OFS_INDEX_CFG, 32'h0);
      step(1'b1);
      step(1'b1);
      chk(encoder_count, 32'h1);
      wr(`OFS_ENC_CONST, 32'h0001_0000);
      repeat (4) step(1'b0);
      chk(encoder_count, 32'hFFFF_FFFD);
      wr(`OFS_INT_MASK, 32'h1);
      cfg = 32'h0;
      for (int k = 0; k < 8; k++) begin
         nc = $urandom & 32'hF;
         // moving the pin may still fire once under the old setting
         qo = (cfg[2] != nc[2])
            && (cfg[3] || ((ph[1] ^ ph[0]) == cfg[0] && ph[1] == cfg[1]));
         cfg = nc;
         c = $urandom;
         idx(~cfg[2]);
         wr(`OFS_INDEX_CFG, cfg);
         step(1'b1);
         wr(`OFS_ENC_COUNT, c);
         wr(`OFS_INT_STATUS, 32'h1);
         rchk(`OFS_INDEX_STATUS, 32'(qo));
         q = cfg[3] || ((ph[1] ^ ph[0]) == cfg[0] && ph[1] == cfg[1]);
         idx(cfg[2]);
         chk(32'(irq), 32'(q));
         idx(~cfg[2]);
         rchk(`OFS_INDEX_STATUS, 32'(q));
         if (q) rchk(`OFS_INDEX_LATCH, c);
      end
      idx(1'b0);
      wr(`OFS_INDEX_CFG, 32'h0000_014C);
      wr(`OFS_ENC_COUNT, 32'h55);
      idx(1'b1);
      chk(encoder_count, 32'h0);
      rchk(`OFS_INDEX_LATCH, 32'h55);
      wr(`OFS_ENC_COUNT, 32'h66);
      idx(1'b0);
      chk(encoder_count, 32'h66);
      wr(`OFS_INDEX_CFG, 32'h0000_018C);
      idx(1'b1);
      chk(encoder_count, 32'h66);
      idx(1'b0);
      chk(encoder_count, 32'h0);
      wr(`OFS_INDEX_CFG, 32'h0000_012C);
      wr(`OFS_ENC_COUNT, 32'h7);
      idx(1'b1);
      idx(1'b0);
      chk(encoder_count, 32'h0);
      wr(`OFS_ENC_COUNT, 32'h9);
      idx(1'b1);
      idx(1'b0);
      chk(encoder_count, 32'h9);
      wr(`OFS_INDEX_CFG, 32'h0000_001C);
      idx(1'b1);
      wr(`OFS_ENC_COUNT, 32'h33);
      step(1'b1);
      chk(encoder_count, 32'h0);
      idx(1'b0);
      wr(`OFS_ENC_COUNT, 32'h33);
      idle(1);
      chk(encoder_count, 32'h33);
      c = $urandom;
      motor_position <= c;
      compare_value <= c;
      wr(`OFS_INDEX_CFG, 32'h0);
      idle(3);
      chk(32'(position_match_output), 32'h1);
      wr(`OFS_INDEX_CFG, 32'h0000_1000);
      compare_value <= 32'h33;
      idle(3);
      chk(32'(position_match_output), 32'h1);
      compare_value <= c;
      idle(3);
      chk(32'(position_match_output), 32'(c == 32'h33));
      wr(`OFS_ANGLE_SCALE, 32'h040);
      wr(`OFS_ANGLE, 32'h10);
      rchk(`OFS_ANGLE, 32'h10);
      step(1'b1);
      step(1'b1);
      rchk(`OFS_ANGLE, 32'h12);
      wr(`OFS_ANGLE_SCALE, 32'hFC0);
      step(1'b1);
      rchk(`OFS_ANGLE, 32'h11);
      for (int r = 0; r < 4; r++) begin
         for (int l = 0; l < 4; l++) begin
            c = $urandom;
            microstep_position <= c[12:0];
            wr(`OFS_ANGLE_SELECT, 32'((l << 8) | r));
            idle(3);
            mang = (r == 0) ? c[12:5] : (r == 1) ? c[11:4] :
                   (r == 2) ? c[9:2] : c[7:0];
            dv = 8'h11 - mang;
            lim = 64 + 8 * l;
            chk(32'(load_status), {29'h0, dv > lim || dv < -lim,
               dv > lim, dv < -lim});
            if (dv <= lim && dv >= -lim)
               chk({24'h0, load_angle}, {24'h0, dv});
         end
      end
      wr(`OFS_ANGLE_SCALE, 32'h0);
      idle(3);
      chk({24'h0, load_angle}, 32'h0);
      complete_run();
   end
endmodule
